/* csmc_pkg.sv */
// Constants, states and carriers of the CPU suspend modulation controller
// Operation
// - Memory window base sits in status_block_base bits 31:8
// - Low byte of status_block_base is read-only and reports window size
// - Suspend command write with full-suspend bit clear starts suspend
// - Unmasked IRQ or SMI ends a software suspend
// - Full-suspend bit set: suspend, then raise low-voltage output on ack
// - On resume wait programmed PLL delay before dropping suspend request
// - Enabled IRQ pins and SMI-enabled GPIOs resume stopped clocks
// - With 32 kHz clock running, internal SMI events also resume
// - Any write to software SMI register raises SMI
// - Modulation alternately asserts and deasserts suspend request
// - Activity (IRQ, port 061h, SMI, video) pauses modulation for a time
// - Video activity comes from processor serial link, decoded to speedups
// - Video activity: VGA regs, VGA buffer, accel regs, graphics buffer
// - Bus master grants leave modulation settings and counters unchanged
// - ON and OFF durations are 8-bit counts of 32 us intervals
// - Modulation runs only while its feature enable bit is one
// - SMI select one: SMI stops modulation until re-enabled; else timed
package csmc_pkg;
  localparam logic [7:0] IDX_PM_EN = 8'h80;
  localparam logic [7:0] IDX_IRQ_SPD = 8'h8c;
  localparam logic [7:0] IDX_VID_SPD = 8'h8d;
  localparam logic [7:0] IDX_GPIO_SMI = 8'h92;
  localparam logic [7:0] IDX_OFF_CNT = 8'h94;
  localparam logic [7:0] IDX_ON_CNT = 8'h95;
  localparam logic [7:0] IDX_CPU_SUSPEND_REQUEST_CFG = 8'h96;
  localparam logic [7:0] IDX_CPU_SUSPEND_REQUEST_CMD = 8'hae;
  localparam logic [7:0] IDX_CLK_STOP = 8'hbc;
  localparam logic [7:0] IDX_SW_SMI = 8'hd0;
  localparam logic [7:0] IDX_F1_BASE = 8'h10;
  localparam logic [7:0] OFF_SPD_DIS = 8'h08;
  localparam logic [3:0] OFF_TIMER_TOP = 4'hf;
  localparam logic [7:0] WIN_SIZE_CODE = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [23:0] BASE_RST = 24'h000000;
  localparam int PM_GLOBAL = 0;
  localparam int PM_IRQ_SPD = 3;
  localparam int PM_VID_SPD = 4;
  localparam int SC_MOD_EN = 0;
  localparam int SC_SMI_SEL = 1;
  localparam int CS_FULL = 0;
  localparam int CS_DLY_LSB = 4;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int TICK_US = 32;
  localparam int TICK_CYC = (TICK_US * 1000000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int MS_CYC = 1000000000 / CLK_PERIOD_PS;

  typedef enum logic [4:0] {
    CSMC_RUN = 5'b00001,
    CSMC_SW_CPU_SUSPEND_REQUEST = 5'b00010,
    CSMC_FULL_ACK = 5'b00100,
    CSMC_FULL_CPU_SUSPEND_REQUEST = 5'b01000,
    CSMC_PLL_WAIT = 5'b10000
  } csmc_state_t;

  typedef struct packed {
    logic vga_reg;
    logic vga_fb;
    logic accel_ctl;
    logic gfx_fb;
  } csmc_video_t;

  typedef struct packed {
    logic external_irq_a;
    logic external_irq_b;
    logic [2:0] gpio;
  } csmc_wake_t;
endpackage : csmc_pkg

/* csmc_tick.sv */
// Free-running interval tick generator
`timescale 1ns/1ps
module csmc_tick #(
  parameter int DIV = 3200
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt_r;

  always_ff @(posedge core_clk) begin
    if (rst || cnt_r == 32'(DIV - 1)) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    tick <= !rst && cnt_r == 32'(DIV - 1);
  end
endmodule : csmc_tick

/* csmc_down.sv */
// Loadable down counter stepped by an interval tick
`timescale 1ns/1ps
module csmc_down #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  output logic busy
);
  logic [W-1:0] cnt_r;

  // Load wins over a tick in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (tick && cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign busy = cnt_r != '0;
endmodule : csmc_down

/* csmc_top.sv */
// CPU suspend, full suspend and suspend modulation controller
`timescale 1ns/1ps
module csmc_top #(
  parameter int MS_DIV = csmc_pkg::MS_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic cfg_func,
  input wire logic [7:0] cfg_index,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_addr,
  output logic mem_hit,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  input wire logic intr_unmasked,
  input wire logic port61_access,
  input wire logic smi_event,
  input wire logic clk32_running,
  input wire csmc_pkg::csmc_video_t processor_serial_link,
  input wire csmc_pkg::csmc_wake_t wake_pins,
  input wire logic [1:0] ext_irq_wake_en,
  input wire logic cpu_suspend_acknowledge_n,
  output logic cpu_suspend_request_n,
  output logic low_voltage_suspend_out,
  output logic smi_out
);
  csmc_pkg::csmc_state_t state_r;
  logic [7:0] pm_en_r, irq_spd_r, vid_spd_r, gpio_smi_r;
  logic [7:0] off_cnt_r, on_cnt_r, cpu_suspend_request_cfg_r, clk_stop_r;
  logic [23:0] base_r;
  logic [31:0] timer_r;
  logic smi_dis_r, phase_on_r, mod_run_q, pll_arm_r;
  logic tick_32us, tick_ms;
  logic f0_wr, cmd_wr, swsmi_wr, smi_any, feat_en, mod_run, resume;
  logic video_ev, irq_load, vid_load, irq_busy, vid_busy, spd_busy;
  logic mod_load, mod_busy, phase_nxt, pll_load, pll_busy, spd_rd;
  logic [7:0] mod_val;
  logic [31:0] f0_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  assign f0_wr = cfg_wr && !cfg_func;
  assign cmd_wr = f0_wr && cfg_index == csmc_pkg::IDX_CPU_SUSPEND_REQUEST_CMD;
  assign swsmi_wr = f0_wr && cfg_index == csmc_pkg::IDX_SW_SMI;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pm_en_r <= csmc_pkg::BYTE_RST;
      irq_spd_r <= csmc_pkg::BYTE_RST;
      vid_spd_r <= csmc_pkg::BYTE_RST;
      gpio_smi_r <= csmc_pkg::BYTE_RST;
      off_cnt_r <= csmc_pkg::BYTE_RST;
      on_cnt_r <= csmc_pkg::BYTE_RST;
      cpu_suspend_request_cfg_r <= csmc_pkg::BYTE_RST;
      clk_stop_r <= csmc_pkg::BYTE_RST;
    end else if (f0_wr) begin
      unique case (cfg_index)
        csmc_pkg::IDX_PM_EN: pm_en_r <= cfg_wdata[7:0];
        csmc_pkg::IDX_IRQ_SPD: irq_spd_r <= cfg_wdata[7:0];
        csmc_pkg::IDX_VID_SPD: vid_spd_r <= cfg_wdata[7:0];
        csmc_pkg::IDX_GPIO_SMI: gpio_smi_r <= cfg_wdata[7:0];
        csmc_pkg::IDX_OFF_CNT: off_cnt_r <= cfg_wdata[7:0];
        csmc_pkg::IDX_ON_CNT: on_cnt_r <= cfg_wdata[7:0];
        csmc_pkg::IDX_CPU_SUSPEND_REQUEST_CFG: cpu_suspend_request_cfg_r <= {5'h00, cfg_wdata[2:0]};
        csmc_pkg::IDX_CLK_STOP: clk_stop_r <= cfg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Low byte is fixed so software can size the window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      base_r <= csmc_pkg::BASE_RST;
    end else if (cfg_wr && cfg_func && cfg_index == csmc_pkg::IDX_F1_BASE)
    begin
      base_r <= cfg_wdata[31:8];
    end
  end

  always_ff @(posedge core_clk) begin
    smi_out <= !rst && smi_any;
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration reads; write-only registers read as zero

  always_comb begin
    f0_rdata = 32'h0;
    unique case (cfg_index)
      csmc_pkg::IDX_PM_EN: f0_rdata[7:0] = pm_en_r;
      csmc_pkg::IDX_IRQ_SPD: f0_rdata[7:0] = irq_spd_r;
      csmc_pkg::IDX_VID_SPD: f0_rdata[7:0] = vid_spd_r;
      csmc_pkg::IDX_GPIO_SMI: f0_rdata[7:0] = gpio_smi_r;
      csmc_pkg::IDX_OFF_CNT: f0_rdata[7:0] = off_cnt_r;
      csmc_pkg::IDX_ON_CNT: f0_rdata[7:0] = on_cnt_r;
      csmc_pkg::IDX_CPU_SUSPEND_REQUEST_CFG: f0_rdata[7:0] = cpu_suspend_request_cfg_r;
      csmc_pkg::IDX_CLK_STOP: f0_rdata[7:0] = clk_stop_r;
      default: ;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_rdata <= 32'h0;
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_rd || cfg_wr;
      if (cfg_rd && cfg_func) begin
        cfg_rdata <= cfg_index == csmc_pkg::IDX_F1_BASE
          ? {base_r, csmc_pkg::WIN_SIZE_CODE} : 32'h0;
      end else if (cfg_rd) begin
        cfg_rdata <= f0_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory window: speedup re-enable and power management timer

  assign mem_hit = (mem_rd || mem_wr) && mem_addr[31:8] == base_r;
  assign spd_rd = mem_rd && mem_hit && mem_addr[7:0] == csmc_pkg::OFF_SPD_DIS;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_r <= 32'h0;
    end else begin
      timer_r <= timer_r + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_rdata <= 32'h0;
      mem_ack <= 1'b0;
    end else begin
      mem_ack <= mem_hit;
      if (mem_rd && mem_hit) begin
        mem_rdata <= mem_addr[7:4] == csmc_pkg::OFF_TIMER_TOP
          ? timer_r : 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Activity speedups

  csmc_tick #(.DIV(csmc_pkg::TICK_CYC)) u_tick32 (
    .core_clk(core_clk), .rst(rst), .tick(tick_32us));
  csmc_tick #(.DIV(MS_DIV)) u_tickms (
    .core_clk(core_clk), .rst(rst), .tick(tick_ms));

  assign feat_en = pm_en_r[csmc_pkg::PM_GLOBAL]
    && cpu_suspend_request_cfg_r[csmc_pkg::SC_MOD_EN];
  assign smi_any = smi_event || swsmi_wr;
  assign video_ev = |processor_serial_link;
  assign irq_load = feat_en && pm_en_r[csmc_pkg::PM_IRQ_SPD]
    && (intr_unmasked || port61_access
    || (smi_any && !cpu_suspend_request_cfg_r[csmc_pkg::SC_SMI_SEL]));
  assign vid_load = feat_en && pm_en_r[csmc_pkg::PM_VID_SPD]
    && video_ev;

  csmc_down #(.W(8)) u_irq_spd (
    .core_clk(core_clk), .rst(rst), .load(irq_load),
    .load_val(irq_spd_r), .tick(tick_ms), .busy(irq_busy));
  csmc_down #(.W(8)) u_vid_spd (
    .core_clk(core_clk), .rst(rst), .load(vid_load),
    .load_val(vid_spd_r), .tick(tick_ms), .busy(vid_busy));
  assign spd_busy = irq_busy || vid_busy;

  // A new SMI in the cycle of the re-enable read keeps modulation off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      smi_dis_r <= 1'b0;
    end else if (smi_any && feat_en && cpu_suspend_request_cfg_r[csmc_pkg::SC_SMI_SEL])
    begin
      smi_dis_r <= 1'b1;
    end else if (spd_rd && feat_en) begin
      smi_dis_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Modulation phases; acknowledge is ignored so bus master grants
  // neither stall nor reset the counters

  assign mod_run = feat_en && !smi_dis_r && !spd_busy
    && state_r == csmc_pkg::CSMC_RUN;
  assign mod_load = mod_run && (!mod_run_q || !mod_busy);
  assign phase_nxt = !mod_run_q || !phase_on_r;
  assign mod_val = phase_nxt ? on_cnt_r : off_cnt_r;

  csmc_down #(.W(8)) u_mod (
    .core_clk(core_clk), .rst(rst), .load(mod_load),
    .load_val(mod_val), .tick(tick_32us && mod_run), .busy(mod_busy));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mod_run_q <= 1'b0;
      phase_on_r <= 1'b0;
    end else begin
      mod_run_q <= mod_run;
      if (mod_load) begin
        phase_on_r <= phase_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software and full suspend sequencing

  assign resume = (wake_pins.external_irq_a && ext_irq_wake_en[0])
    || (wake_pins.external_irq_b && ext_irq_wake_en[1])
    || |(wake_pins.gpio & gpio_smi_r[2:0])
    || (clk32_running && smi_event);
  assign pll_load = state_r == csmc_pkg::CSMC_FULL_CPU_SUSPEND_REQUEST && resume;

  csmc_down #(.W(4)) u_pll (
    .core_clk(core_clk), .rst(rst), .load(pll_load),
    .load_val(clk_stop_r[csmc_pkg::CS_DLY_LSB +: 4]), .tick(tick_ms),
    .busy(pll_busy));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= csmc_pkg::CSMC_RUN;
    end else begin
      unique case (state_r)
        csmc_pkg::CSMC_RUN: begin
          if (cmd_wr) begin
            state_r <= clk_stop_r[csmc_pkg::CS_FULL]
              ? csmc_pkg::CSMC_FULL_ACK
              : csmc_pkg::CSMC_SW_CPU_SUSPEND_REQUEST;
          end
        end
        csmc_pkg::CSMC_SW_CPU_SUSPEND_REQUEST: begin
          if (intr_unmasked || smi_any) begin
            state_r <= csmc_pkg::CSMC_RUN;
          end
        end
        csmc_pkg::CSMC_FULL_ACK: begin
          if (!cpu_suspend_acknowledge_n) begin
            state_r <= csmc_pkg::CSMC_FULL_CPU_SUSPEND_REQUEST;
          end
        end
        csmc_pkg::CSMC_FULL_CPU_SUSPEND_REQUEST: begin
          if (resume) begin
            state_r <= csmc_pkg::CSMC_PLL_WAIT;
          end
        end
        csmc_pkg::CSMC_PLL_WAIT: begin
          if (!pll_arm_r && !pll_busy) begin
            state_r <= csmc_pkg::CSMC_RUN;
          end
        end
        default: state_r <= csmc_pkg::CSMC_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    pll_arm_r <= !rst && pll_load;
  end

  // Registered so the pin never glitches between phases
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpu_suspend_request_n <= 1'b1;
      low_voltage_suspend_out <= 1'b0;
    end else begin
      cpu_suspend_request_n <= !(
        state_r != csmc_pkg::CSMC_RUN && !(
        state_r == csmc_pkg::CSMC_PLL_WAIT && !pll_arm_r && !pll_busy)
        || (mod_run && phase_on_r && !mod_load));
      low_voltage_suspend_out <= state_r == csmc_pkg::CSMC_FULL_CPU_SUSPEND_REQUEST
        && !resume;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  swsmi_pulse_a: assert property (swsmi_wr |=> smi_out)
    else $error("software SMI write gave no SMI");
  swsusp_req_a: assert property (
    cmd_wr && state_r == csmc_pkg::CSMC_RUN && !clk_stop_r[csmc_pkg::CS_FULL]
    |=> ##1 !cpu_suspend_request_n)
    else $error("suspend command did not raise request");
  swsusp_wake_a: assert property (
    state_r == csmc_pkg::CSMC_SW_CPU_SUSPEND_REQUEST && (intr_unmasked || smi_any)
    |=> state_r == csmc_pkg::CSMC_RUN)
    else $error("interrupt did not end software suspend");
  lv_after_ack_a: assert property (
    low_voltage_suspend_out |-> $past(state_r) == csmc_pkg::CSMC_FULL_CPU_SUSPEND_REQUEST)
    else $error("low-voltage output outside full suspend");
  pll_hold_a: assert property (
    pll_arm_r |=> !cpu_suspend_request_n)
    else $error("request dropped before PLL delay");
  wake_only_a: assert property (
    state_r == csmc_pkg::CSMC_FULL_CPU_SUSPEND_REQUEST && !resume
    |=> state_r == csmc_pkg::CSMC_FULL_CPU_SUSPEND_REQUEST)
    else $error("full suspend left without resume event");
  speedup_hold_a: assert property (
    spd_busy && state_r == csmc_pkg::CSMC_RUN
    && $past(state_r) == csmc_pkg::CSMC_RUN |=> cpu_suspend_request_n)
    else $error("request asserted during speedup");
  mod_off_a: assert property (
    !feat_en && state_r == csmc_pkg::CSMC_RUN
    && $past(state_r) == csmc_pkg::CSMC_RUN |=> cpu_suspend_request_n)
    else $error("modulation ran while disabled");
  base_low_a: assert property (
    cfg_rd && cfg_func && cfg_index == csmc_pkg::IDX_F1_BASE
    |=> cfg_rdata[7:0] == csmc_pkg::WIN_SIZE_CODE)
    else $error("window size byte wrong");
  smi_dis_a: assert property (
    smi_any && feat_en && cpu_suspend_request_cfg_r[csmc_pkg::SC_SMI_SEL]
    |=> smi_dis_r && !mod_run)
    else $error("SMI did not stop modulation");

  mod_phase_c: cover property (
    mod_run && phase_on_r ##1 mod_run && !phase_on_r);
  full_cycle_c: cover property (
    state_r == csmc_pkg::CSMC_PLL_WAIT ##1 state_r == csmc_pkg::CSMC_RUN);
  speedup_c: cover property (mod_run ##1 spd_busy);
endmodule : csmc_top

/* csmc_cpu_model.sv */
// Processor model answering the suspend request handshake
`timescale 1ns/1ps
module csmc_cpu_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cpu_suspend_request_n,
  input wire logic bus_master_req,
  input wire logic [3:0] ack_delay,
  output logic cpu_suspend_acknowledge_n,
  output logic core_running
);
  logic [3:0] wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // A bus master request drops the halt acknowledge until it is withdrawn
  always_ff @(posedge core_clk) begin
    if (rst || cpu_suspend_request_n || bus_master_req) begin
      wait_r <= 4'h0;
      cpu_suspend_acknowledge_n <= 1'b1;
    end else if (wait_r < ack_delay) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      cpu_suspend_acknowledge_n <= 1'b0;
    end
  end

  // Core clocks stand still only while the halt is acknowledged
  assign core_running = cpu_suspend_acknowledge_n;
endmodule : csmc_cpu_model

/* csmc_top_test.sv */
// Self-checking bench for the suspend modulation controller
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  failures++; $display("wrong value %s expected %h seen %h", nm, ex, gt); \
  end end
module csmc_top_test;
  localparam int MS = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic cfg_func = 1'b0;
  logic [7:0] cfg_index = 8'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic mem_rd = 1'b0;
  logic [31:0] mem_addr = 32'h0;
  logic [6:0] act = 7'h00;
  logic clk32_running = 1'b0;
  logic [4:0] wk = 5'h00;
  logic [1:0] ext_irq_wake_en = 2'h0;
  logic bus_master_req = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  logic [31:0] cfg_rdata, mem_rdata, rd, t1;
  logic cfg_ack, mem_hit, mem_ack, smi_out, last_smi, h, a;
  logic cpu_suspend_acknowledge_n, cpu_suspend_request_n;
  logic low_voltage_suspend_out, core_running;
  csmc_pkg::csmc_video_t vid;
  csmc_pkg::csmc_wake_t wake;
  int failures = 0;
  int compares = 0;
  int n;
  logic [7:0] rw_idx [6] = '{8'h8c, 8'h8d, 8'h92, 8'h94, 8'h95, 8'h96};
  logic [7:0] rw_exp [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07};
  logic [7:0] ro_idx [5] = '{8'h80, 8'hbc, 8'hae, 8'hd0, 8'h55};

  assign vid = act[6:3];
  assign wake = wk;
  always #5 core_clk = ~core_clk;

  csmc_top #(.MS_DIV(MS)) csmc_top_inst (
    .core_clk(core_clk),
    .rst(rst),
    .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd),
    .cfg_func(cfg_func),
    .cfg_index(cfg_index),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack),
    .mem_rd(mem_rd),
    .mem_wr(1'b0),
    .mem_addr(mem_addr),
    .mem_hit(mem_hit),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack),
    .intr_unmasked(act[2]),
    .port61_access(act[0]),
    .smi_event(act[1]),
    .clk32_running(clk32_running),
    .processor_serial_link(vid),
    .wake_pins(wake),
    .ext_irq_wake_en(ext_irq_wake_en),
    .cpu_suspend_acknowledge_n(cpu_suspend_acknowledge_n),
    .cpu_suspend_request_n(cpu_suspend_request_n),
    .low_voltage_suspend_out(low_voltage_suspend_out),
    .smi_out(smi_out)
  );

  csmc_cpu_model csmc_cpu_model_inst (
    .core_clk(core_clk),
    .rst(rst),
    .cpu_suspend_request_n(cpu_suspend_request_n),
    .bus_master_req(bus_master_req),
    .ack_delay(ack_delay),
    .cpu_suspend_acknowledge_n(cpu_suspend_acknowledge_n),
    .core_running(core_running)
  );

  //////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task test_end(input string nm);
    $display("test %s done", nm);
  endtask : test_end

  // Strobes are one-cycle pulses; ack and data are taken one cycle later
  task cfg_xfer(input logic wr, input logic fn, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge core_clk);
    cfg_wr <= wr;
    cfg_rd <= ~wr;
    cfg_func <= fn;
    cfg_index <= idx;
    cfg_wdata <= wd;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
    `CHK("cfg_ack", 1'b1, cfg_ack);
    last_smi = smi_out;
    rdv = cfg_rdata;
  endtask : cfg_xfer

  task wr0(input logic [7:0] idx, input logic [7:0] v);
    cfg_xfer(1'b1, 1'b0, idx, {24'h0, v}, rd);
  endtask : wr0

  task mem_read(input logic [31:0] ad);
    @(posedge core_clk);
    mem_rd <= 1'b1;
    mem_addr <= ad;
    #1;
    h = mem_hit;
    @(posedge core_clk);
    mem_rd <= 1'b0;
    #1;
    a = mem_ack;
    rd = mem_rdata;
  endtask : mem_read

  // Counts cycles until request (sel 0) or low-voltage (sel 1) reaches lvl
  task wait_sig(input bit sel, input logic lvl, input int lim, input bit must,
      output int cnt);
    cnt = 0;
    while ((sel ? low_voltage_suspend_out : cpu_suspend_request_n) !== lvl
        && cnt < lim) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    if (must && (sel ? low_voltage_suspend_out : cpu_suspend_request_n)
        !== lvl) begin
      failures++;
      $display("wait limit reached");
      tally_and_finish();
    end
  endtask : wait_sig

  task pulse(input int b);
    @(posedge core_clk);
    act[b] <= 1'b1;
    @(posedge core_clk);
    act <= 7'h00;
    #1;
  endtask : pulse

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    wr0(8'h55, 8'hff);
    for (int i = 0; i < 6; i++) begin
      cfg_xfer(1'b0, 1'b0, rw_idx[i], 32'h0, rd);
      `CHK("reg reset", 32'h0, rd);
      wr0(rw_idx[i], 8'hff);
      cfg_xfer(1'b0, 1'b0, rw_idx[i], 32'h0, rd);
      `CHK("reg readback", {24'h0, rw_exp[i]}, rd);
      wr0(rw_idx[i], 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      cfg_xfer(1'b0, 1'b0, ro_idx[i], 32'h0, rd);
      `CHK("reads zero", 32'h0, rd);
    end
    test_end("registers");
    cfg_xfer(1'b1, 1'b1, 8'h10, 32'h123456ff, rd);
    cfg_xfer(1'b0, 1'b1, 8'h10, 32'h0, rd);
    `CHK("base", {24'h123456, csmc_pkg::WIN_SIZE_CODE}, rd);
    mem_read(32'h123456f0);
    t1 = rd;
    `CHK("hit", 1'b1, h);
    `CHK("mem_ack", 1'b1, a);
    mem_read(32'h123456fc);
    `CHK("timer runs", t1 + 32'h2, rd);
    mem_read(32'h123457f0);
    `CHK("miss hit", 1'b0, h);
    `CHK("miss ack", 1'b0, a);
    test_end("window");
    for (int i = 0; i < 2; i++) begin
      wr0(csmc_pkg::IDX_SW_SMI, i ? 8'hff : 8'h00);
      `CHK("smi_out", 1'b1, last_smi);
    end
    test_end("software smi");
    ack_delay <= 4'h5;
    for (int j = 0; j < 2; j++) begin
      wr0(csmc_pkg::IDX_CPU_SUSPEND_REQUEST_CMD, j ? 8'h3c : 8'h00);
      wait_sig(1'b0, 1'b0, 4, 1'b1, n);
      `CHK("request delay", 1'b1, n == 1);
      repeat (20) @(posedge core_clk);
      #1;
      `CHK("held", 1'b0, cpu_suspend_request_n);
      `CHK("core stopped", 1'b0, core_running);
      pulse(j ? 1 : 2);
      wait_sig(1'b0, 1'b1, 6, 1'b1, n);
      repeat (10) @(posedge core_clk);
    end
    test_end("software suspend");
    ext_irq_wake_en <= 2'b01;
    wr0(csmc_pkg::IDX_GPIO_SMI, 8'h01);
    wr0(csmc_pkg::IDX_CLK_STOP, 8'h21);
    for (int k = 0; k < 3; k++) begin
      clk32_running <= (k == 2);
      wr0(csmc_pkg::IDX_CPU_SUSPEND_REQUEST_CMD, 8'h00);
      wait_sig(1'b1, 1'b1, 60, 1'b1, n);
      `CHK("req in full", 1'b0, cpu_suspend_request_n);
      @(posedge core_clk);
      wk <= 5'b01110;
      repeat (30) @(posedge core_clk);
      #1;
      `CHK("no wake", 1'b1, low_voltage_suspend_out);
      @(posedge core_clk);
      wk <= (k == 0) ? 5'b10000 : (k == 1) ? 5'b00001 : 5'b00000;
      if (k == 2) begin
        pulse(1);
      end
      wait_sig(1'b1, 1'b0, 5, 1'b1, n);
      wait_sig(1'b0, 1'b1, 200, 1'b1, n);
      `CHK("pll wait", 1'b1, n >= MS && n <= 3 * MS + 10);
      @(posedge core_clk);
      wk <= 5'b00000;
    end
    test_end("full suspend");
    // Speedup timers armed as software would for major I/O
    wr0(csmc_pkg::IDX_OFF_CNT, 8'h02);
    wr0(csmc_pkg::IDX_ON_CNT, 8'h02);
    wr0(csmc_pkg::IDX_IRQ_SPD, 8'h02);
    wr0(csmc_pkg::IDX_VID_SPD, 8'h02);
    wr0(csmc_pkg::IDX_PM_EN, 8'h19);
    wait_sig(1'b0, 1'b0, 7000, 1'b0, n);
    `CHK("feature off", 1'b1, cpu_suspend_request_n);
    wr0(csmc_pkg::IDX_CPU_SUSPEND_REQUEST_CFG, 8'h01);
    wait_sig(1'b0, 1'b0, 7000, 1'b1, n);
    @(posedge core_clk);
    bus_master_req <= 1'b1;
    repeat (40) @(posedge core_clk);
    bus_master_req <= 1'b0;
    #1;
    `CHK("bus master ack", 1'b1, cpu_suspend_acknowledge_n);
    wait_sig(1'b0, 1'b1, 7000, 1'b1, n);
    `CHK("on len", 1'b1, n + 42 >= 3150 && n + 42 <= 6450);
    wait_sig(1'b0, 1'b0, 7000, 1'b1, n);
    `CHK("off len", 1'b1, n >= 3150 && n <= 6450);
    for (int i = 0; i < 7; i++) begin
      wait_sig(1'b0, 1'b0, 7000, 1'b1, n);
      pulse(i);
      wait_sig(1'b0, 1'b1, 5, 1'b1, n);
      wait_sig(1'b0, 1'b0, 200, 1'b1, n);
      `CHK("speedup len", 1'b1, n >= MS - 5);
    end
    test_end("modulation");
    wr0(csmc_pkg::IDX_CPU_SUSPEND_REQUEST_CFG, 8'h03);
    wait_sig(1'b0, 1'b0, 7000, 1'b1, n);
    pulse(1);
    wait_sig(1'b0, 1'b1, 5, 1'b1, n);
    wait_sig(1'b0, 1'b0, 7000, 1'b0, n);
    `CHK("smi disable", 1'b1, cpu_suspend_request_n);
    mem_read(32'h12345608);
    wait_sig(1'b0, 1'b0, 7000, 1'b1, n);
    wr0(csmc_pkg::IDX_CPU_SUSPEND_REQUEST_CFG, 8'h00);
    wait_sig(1'b0, 1'b1, 7000, 1'b1, n);
    wait_sig(1'b0, 1'b0, 7000, 1'b0, n);
    `CHK("stopped", 1'b1, cpu_suspend_request_n);
    test_end("smi speedup");
    tally_and_finish();
  end
endmodule : csmc_top_test
